// *** verilog/pbl_pkg.sv ***
// Shared constants and carrier types for the program RAM boot loader
package pbl_pkg;
	// Memory sizes
	localparam int PROGRAM_RAM_WORDS = 512;
	localparam int ROM_WORDS  = 32;
	localparam int WORD_W     = 24;
	// Operating modes
	localparam logic [1:0] MODE_BOOT   = 2'h1;
	localparam logic [1:0] MODE_NORMAL = 2'h2;
	// External boot image layout
	localparam logic [15:0] EXT_BOOT_BASE = 16'hC000;
	localparam logic [8:0]  LAST_WORD     = 9'h1FF;
	localparam int          SRC_SEL_BIT   = 23;
	// Byte slots within a word
	localparam logic [1:0] BYTE_LOW  = 2'h0;
	localparam logic [1:0] BYTE_MID  = 2'h1;
	localparam logic [1:0] BYTE_HIGH = 2'h2;
	// Timing
	localparam int CLK_PERIOD_NS  = 8;
	localparam int EXT_ACCESS_NS  = 40;
	localparam int SYNC_STAGES    = 2;
	localparam logic [3:0] EXT_WAIT_CYC =
		4'((EXT_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_STAGES + 1);
	localparam int SWITCH_INSTR_CYC = 1;
	localparam int SWITCH_JUMP_CYC  = 2;
	localparam logic [1:0] SWITCH_DELAY_CYC = 2'(SWITCH_INSTR_CYC + SWITCH_JUMP_CYC);
	// Loader states
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_SEL  = 3'b001,
		ST_EXT  = 3'b010,
		ST_HOST = 3'b011,
		ST_DONE = 3'b100
	} pbl_state_e;
	// One byte from the host interface transmit registers
	typedef struct packed {
		logic       valid;
		logic [1:0] sel;
		logic [7:0] data;
	} pbl_host_s;
	// One program RAM write
	typedef struct packed {
		logic        en;
		logic [8:0]  addr;
		logic [23:0] data;
	} pbl_pwr_s;
endpackage : pbl_pkg

// *** verilog/pbl_sync.sv ***
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ns
`default_nettype none
module pbl_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clk_sys,
	input  wire logic         rstn,
	// Data
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] stage1;
	logic [W-1:0] next_stage1;
	logic [W-1:0] next_q;

	// First stage feeds only the second
	always_comb begin
		next_stage1 = d;
		next_q      = stage1;
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			stage1 <= '0;
			q      <= '0;
		end else begin
			stage1 <= next_stage1;
			q      <= next_q;
		end
	end
endmodule : pbl_sync
`default_nettype wire

// *** verilog/pbl_boot_ctrl.sv ***
// Boot mode control: boot ROM mapping, program RAM and loader sequencer
// Behaviour
// R1: 32-word boot ROM, hidden in normal operation
// R2: Mode 1 keeps boot ROM mapped
// R3: Reset in mode 1 maps ROM at zero
// R4: During boot, reads hit ROM, writes RAM
// R5: Boot starts at zero, loads RAM
// R6: Mode 2 unmaps ROM, restores RAM access
// R7: Switch to mode 2 delayed, then jump
// R8: Writing mode 1 remaps ROM after delay
// R9: Bit 23 at C000 selects source
// R10: External bytes low, mid, high per word
// R11: Host writes high, mid, low bytes
// R12: Host flag zero ends boot early
// R13: Host words accepted without handshake polling
// R14: Last word ends boot automatically
`timescale 1ns/1ns
`default_nettype none
module pbl_boot_ctrl
	import pbl_pkg::*;
#(
	parameter logic [ROM_WORDS*WORD_W-1:0] BOOT_ROM_IMAGE = '0
) (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rstn,
	// Mode straps and operating mode register
	input  wire logic [1:0]  mode_pins,
	input  wire logic        omr_wr,
	input  wire logic [1:0]  omr_wdata,
	output logic      [1:0]  operating_mode,
	// Core program space port
	input  wire logic        core_rd,
	input  wire logic        core_wr,
	input  wire logic [15:0] core_addr,
	input  wire logic [23:0] core_wdata,
	output logic      [23:0] core_rdata,
	output logic             core_hold,
	output logic             core_jump_zero,
	// External byte-wide boot memory
	output logic      [15:0] ext_addr,
	output logic             ext_rd,
	input  wire logic [23:0] ext_data,
	// Host interface transmit bytes
	input  wire pbl_host_s   host_tx,
	input  wire logic        host_flag_zero,
	output logic             host_ready
);
	// Synchronised pins
	logic [23:0] ext_sync;
	logic [1:0]  mode_sync;

	pbl_sync #(.W(26)) u_sync (
		.clk_sys (clk_sys),
		.rstn    (rstn),
		.d       ({mode_pins, ext_data}),
		.q       ({mode_sync, ext_sync})
	);

	// Mode group state
	logic       strap_done, next_strap_done;
	logic [1:0] strap_cnt, next_strap_cnt;
	logic       pend, next_pend;
	logic [1:0] pend_mode, next_pend_mode;
	logic [1:0] dly_cnt, next_dly_cnt;
	logic [1:0] next_operating_mode;
	logic       next_jump;
	logic       load_start, next_load_start;
	logic       rom_map;
	logic       load_done;

	// Loader group state
	pbl_state_e  state, next_state;
	logic [15:0] next_ext_addr;
	logic [8:0]  word_idx, next_word_idx;
	logic [1:0]  byte_idx, next_byte_idx;
	logic [3:0]  wait_cnt, next_wait_cnt;
	logic [23:0] hold, next_hold;
	pbl_pwr_s    pwr;

	// Program storage and read path
	logic [23:0] program_ram [PROGRAM_RAM_WORDS];
	logic [23:0] next_rdata;

	// R2: ROM mapped exactly while in mode 1
	assign rom_map   = (operating_mode == MODE_BOOT);
	assign load_done = (state == ST_DONE);
	assign core_hold = (state != ST_IDLE);
	// R13: host bytes taken every cycle, no wait state
	assign host_ready = (state == ST_HOST);
	assign ext_rd     = (state == ST_SEL) || (state == ST_EXT);

	// Mode switching; loader completion outranks a software write
	always_comb begin
		next_strap_done     = strap_done;
		next_strap_cnt      = strap_cnt;
		next_pend           = pend;
		next_pend_mode      = pend_mode;
		next_dly_cnt        = dly_cnt;
		next_operating_mode = operating_mode;
		next_jump           = 1'b0;
		next_load_start     = 1'b0;
		if (!strap_done) begin
			// R3: strap caught once the synchroniser holds the pins
			// The synchroniser comes out of reset at zero, so an early catch reads mode 0
			if (strap_cnt == 2'(SYNC_STAGES)) begin
				next_strap_done     = 1'b1;
				next_operating_mode = mode_sync;
				next_load_start     = (mode_sync == MODE_BOOT);
			end else begin
				next_strap_cnt = 2'(strap_cnt + 2'h1);
			end
		end else if (pend) begin
			if (dly_cnt == SWITCH_DELAY_CYC - 2'h1) begin
				// R7: one instruction plus jump elapsed
				next_pend           = 1'b0;
				next_operating_mode = pend_mode;
				next_jump           = 1'b1;
				// R8: remap restarts the load
				next_load_start     = (pend_mode == MODE_BOOT);
			end else begin
				next_dly_cnt = 2'(dly_cnt + 2'h1);
			end
		end else if (load_done) begin
			// R6: firmware-equivalent write of mode 2
			next_pend      = 1'b1;
			next_pend_mode = MODE_NORMAL;
			next_dly_cnt   = 2'h0;
		end else if (omr_wr) begin
			// R8: software mode write is timed
			next_pend      = 1'b1;
			next_pend_mode = omr_wdata;
			next_dly_cnt   = 2'h0;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			strap_done     <= 1'b0;
			strap_cnt      <= 2'h0;
			pend           <= 1'b0;
			pend_mode      <= MODE_NORMAL;
			dly_cnt        <= 2'h0;
			operating_mode <= MODE_NORMAL;
			core_jump_zero <= 1'b0;
			load_start     <= 1'b0;
		end else begin
			strap_done     <= next_strap_done;
			strap_cnt      <= next_strap_cnt;
			pend           <= next_pend;
			pend_mode      <= next_pend_mode;
			dly_cnt        <= next_dly_cnt;
			operating_mode <= next_operating_mode;
			core_jump_zero <= next_jump;
			load_start     <= next_load_start;
		end
	end

	// Loader sequencer standing in for the boot firmware
	always_comb begin
		next_state    = state;
		next_ext_addr = ext_addr;
		next_word_idx = word_idx;
		next_byte_idx = byte_idx;
		next_wait_cnt = wait_cnt;
		next_hold     = hold;
		pwr           = '0;
		unique case (state)
			ST_IDLE: begin
				if (load_start) begin
					// R5: begin loading from word zero
					next_state    = ST_SEL;
					next_ext_addr = EXT_BOOT_BASE;
					next_wait_cnt = EXT_WAIT_CYC;
					next_word_idx = 9'h000;
					next_byte_idx = BYTE_LOW;
				end
			end
			ST_SEL: begin
				if (wait_cnt == 4'h0) begin
					// R9: bit 23 picks external or host
					next_state    = ext_sync[SRC_SEL_BIT] ? ST_EXT : ST_HOST;
					next_wait_cnt = EXT_WAIT_CYC;
				end else begin
					next_wait_cnt = 4'(wait_cnt - 4'h1);
				end
			end
			ST_EXT: begin
				if (wait_cnt == 4'h0) begin
					// R10: bytes arrive low, mid, high
					next_hold[byte_idx*8 +: 8] = ext_sync[7:0];
					next_ext_addr = 16'(ext_addr + 16'h0001);
					next_wait_cnt = EXT_WAIT_CYC;
					if (byte_idx == BYTE_HIGH) begin
						pwr.en        = 1'b1;
						pwr.addr      = word_idx;
						pwr.data      = {ext_sync[7:0], hold[15:0]};
						next_byte_idx = BYTE_LOW;
						next_word_idx = 9'(word_idx + 9'h001);
						// R14: last word ends the load
						if (word_idx == LAST_WORD) begin
							next_state = ST_DONE;
						end
					end else begin
						next_byte_idx = 2'(byte_idx + 2'h1);
					end
				end else begin
					next_wait_cnt = 4'(wait_cnt - 4'h1);
				end
			end
			ST_HOST: begin
				if (host_flag_zero) begin
					// R12: host cuts the load short
					next_state = ST_DONE;
				end else if (host_tx.valid) begin
					// R11: low byte completes the word
					next_hold[host_tx.sel*8 +: 8] = host_tx.data;
					if (host_tx.sel == BYTE_LOW) begin
						pwr.en        = 1'b1;
						pwr.addr      = word_idx;
						pwr.data      = {hold[23:8], host_tx.data};
						next_word_idx = 9'(word_idx + 9'h001);
						// R14: last word ends the load
						if (word_idx == LAST_WORD) begin
							next_state = ST_DONE;
						end
					end
				end
			end
			ST_DONE: begin
				next_state = ST_IDLE;
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			state    <= ST_IDLE;
			ext_addr <= EXT_BOOT_BASE;
			word_idx <= 9'h000;
			byte_idx <= BYTE_LOW;
			wait_cnt <= 4'h0;
			hold     <= 24'h000000;
		end else begin
			state    <= next_state;
			ext_addr <= next_ext_addr;
			word_idx <= next_word_idx;
			byte_idx <= next_byte_idx;
			wait_cnt <= next_wait_cnt;
			hold     <= next_hold;
		end
	end

	// Read path: ROM while mapped, otherwise program RAM below 512 and zero above
	always_comb begin
		next_rdata = core_rdata;
		if (core_rd) begin
			if (rom_map) begin
				// R4: all reads come from the boot ROM
				next_rdata = BOOT_ROM_IMAGE[int'(core_addr[4:0])*WORD_W +: WORD_W];
			end else if (core_addr < 16'(PROGRAM_RAM_WORDS)) begin
				// R1: ROM unreachable outside boot
				next_rdata = program_ram[core_addr[8:0]];
			end else begin
				next_rdata = 24'h000000;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			core_rdata <= 24'h000000;
		end else begin
			core_rdata <= next_rdata;
		end
	end

	// Storage has no reset; loader writes take priority over the core
	always_ff @(posedge clk_sys) begin
		if (pwr.en) begin
			program_ram[pwr.addr] <= pwr.data;
		end else if (core_wr && core_addr < 16'(PROGRAM_RAM_WORDS)) begin
			program_ram[core_addr[8:0]] <= core_wdata;
		end
	end

	// Checks
	a_rom_read_boot: assert property (@(posedge clk_sys) disable iff (!rstn) // R4
		core_rd && rom_map |=> core_rdata ==
			BOOT_ROM_IMAGE[int'($past(core_addr[4:0]))*WORD_W +: WORD_W])
		else $error("boot read did not return ROM word");
	a_ram_read_norm: assert property (@(posedge clk_sys) disable iff (!rstn) // R6
		core_rd && !rom_map && core_addr < 16'h0200 && !pwr.en && !core_wr
			|=> core_rdata == program_ram[$past(core_addr[8:0])])
		else $error("normal read did not return RAM word");
	a_boot_end_timed: assert property (@(posedge clk_sys) disable iff (!rstn) // R7
		load_done && !pend && strap_done |-> ##4 (core_jump_zero && operating_mode == MODE_NORMAL))
		else $error("mode 2 switch not on time");
	a_reboot_timed: assert property (@(posedge clk_sys) disable iff (!rstn) // R8
		omr_wr && omr_wdata == MODE_BOOT && !pend && !load_done && strap_done
			|-> !rom_map [*1] ##4 (rom_map && core_jump_zero) or rom_map)
		else $error("reboot remap not on time");
	a_mode_hold: assert property (@(posedge clk_sys) disable iff (!rstn) // R2
		rom_map && !pend && strap_done |=> rom_map)
		else $error("boot ROM dropped while in mode 1");
	a_src_select: assert property (@(posedge clk_sys) disable iff (!rstn) // R9
		state == ST_SEL && wait_cnt == 4'h0
			|=> state == ($past(ext_sync[SRC_SEL_BIT]) ? ST_EXT : ST_HOST))
		else $error("wrong boot source chosen");
	a_host_flag_end: assert property (@(posedge clk_sys) disable iff (!rstn) // R12
		state == ST_HOST && host_flag_zero |=> load_done ##1 state == ST_IDLE)
		else $error("host flag did not end boot");
	a_last_word_end: assert property (@(posedge clk_sys) disable iff (!rstn) // R14
		pwr.en && pwr.addr == LAST_WORD |=> load_done)
		else $error("last word did not end boot");
	a_host_accept: assert property (@(posedge clk_sys) disable iff (!rstn) // R13
		state == ST_HOST && host_tx.valid && host_tx.sel == BYTE_LOW && !host_flag_zero
			|=> word_idx == 9'($past(word_idx) + 9'h001) || load_done)
		else $error("host word not taken at once");
	a_ext_order: assert property (@(posedge clk_sys) disable iff (!rstn) // R10
		pwr.en && state == ST_EXT |-> byte_idx == BYTE_HIGH &&
			ext_addr == 16'(EXT_BOOT_BASE + 16'(3 * int'(word_idx)) + 16'h0002))
		else $error("external word assembled out of order");
endmodule : pbl_boot_ctrl
`default_nettype wire

// *** bench/pbl_boot_mem.sv ***
// Byte-wide external boot memory model for the loader bench
`timescale 1ns/1ns
`default_nettype none
module pbl_boot_mem (
	// Clock
	input  wire logic        clk_sys,
	// Memory side
	input  wire logic [15:0] ext_addr,
	input  wire logic        ext_rd,
	input  wire logic        sel_ext,
	output logic      [23:0] ext_data
);
	// Inverted level on idle cycles so stale data never looks valid
	initial ext_data = 24'hA5A5A5;
	// source bit and one byte per address
	always @(posedge clk_sys) begin
		if (ext_rd)
			ext_data <= {sel_ext, 15'h0000, ext_addr[7:0] ^ {2{ext_addr[11:8]}}};
		else
			ext_data <= ~ext_data;
	end
endmodule : pbl_boot_mem
`default_nettype wire

// *** bench/tb_pbl_boot_ctrl.sv ***
// Self-checking bench for the program RAM boot loader
`timescale 1ns/1ns
`default_nettype none
module tb_pbl_boot_ctrl;
	import pbl_pkg::*;
	logic        clk_sys = 1'b0;
	logic        rstn = 1'b0;
	logic [1:0]  mode_pins = 2'h2;
	logic        omr_wr = 1'b0;
	logic [1:0]  omr_wdata = 2'h0;
	logic [1:0]  operating_mode;
	logic        core_rd = 1'b0;
	logic        core_wr = 1'b0;
	logic [15:0] core_addr = 16'h0000;
	logic [23:0] core_wdata = 24'h000000;
	logic [23:0] core_rdata;
	logic        core_hold;
	logic        core_jump_zero;
	logic [15:0] ext_addr;
	logic        ext_rd;
	logic [23:0] ext_data;
	pbl_host_s   host_tx = '0;
	logic        host_flag_zero = 1'b0;
	logic        host_ready;
	logic        sel_ext = 1'b0;
	int          fail_count = 0;
	int          check_count = 0;

	// Clock, 8 ns period
	always #4 clk_sys = ~clk_sys;

	pbl_boot_ctrl DUT (.clk_sys(clk_sys), .rstn(rstn), .mode_pins(mode_pins),
		.omr_wr(omr_wr), .omr_wdata(omr_wdata), .operating_mode(operating_mode),
		.core_rd(core_rd), .core_wr(core_wr), .core_addr(core_addr),
		.core_wdata(core_wdata), .core_rdata(core_rdata), .core_hold(core_hold),
		.core_jump_zero(core_jump_zero), .ext_addr(ext_addr), .ext_rd(ext_rd),
		.ext_data(ext_data), .host_tx(host_tx), .host_flag_zero(host_flag_zero),
		.host_ready(host_ready));

	pbl_boot_mem mem (.clk_sys(clk_sys), .ext_addr(ext_addr), .ext_rd(ext_rd),
		.sel_ext(sel_ext), .ext_data(ext_data));

	task chk(input string n, input logic [23:0] e, input logic [23:0] g);
		check_count++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task finish_test;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : finish_test

	// Expected word n of the external image: low, mid, high bytes
	function automatic logic [23:0] ext_exp(input int n);
		logic [15:0] a;
		logic [7:0]  b [3];
		a = 16'hC000 + 16'(3 * n);
		for (int k = 0; k < 3; k++)
			b[k] = 8'(a + 16'(k)) ^ {2{4'((a + 16'(k)) >> 8)}};
		return {b[2], b[1], b[0]};
	endfunction : ext_exp

	// Reset with straps; outputs are checked while reset is held
	task do_reset(input logic [1:0] p);
		@(posedge clk_sys);
		rstn <= 1'b0;
		mode_pins <= p;
		repeat (6) @(posedge clk_sys);
		#1 chk("reset outs", {2'h2, 16'hC000, 4'h0},
			{operating_mode, ext_addr, ext_rd, host_ready, core_hold, core_jump_zero});
		chk("reset rdata", 24'h000000, core_rdata);
		@(posedge clk_sys);
		rstn <= 1'b1;
	endtask : do_reset

	// Timed mode write: old mode for two edges after the write, new one with jump on the third
	task operating_mode_register(input logic [1:0] v, input logic [1:0] old);
		@(posedge clk_sys);
		omr_wr <= 1'b1;
		omr_wdata <= v;
		@(posedge clk_sys);
		omr_wr <= 1'b0;
		repeat (2) @(posedge clk_sys);
		#1 chk("mode held", old, operating_mode);
		@(posedge clk_sys);
		#1 chk("mode new", v, operating_mode);
		chk("jump pulse", 24'h1, core_jump_zero);
	endtask : operating_mode_register

	// Bounded wait for a mode; optionally the jump pulse in the same cycle
	task wait_mode(input logic [1:0] v, input int n, input logic j);
		int i;
		i = 0;
		while (operating_mode !== v) begin
			@(posedge clk_sys) #1;
			i++;
			if (i > n) begin
				fail_count++;
				$display("[FAIL] mode wait expected %h seen %h", v, operating_mode);
				finish_test();
			end
		end
		if (j)
			chk("jump pulse", 24'h1, core_jump_zero);
	endtask : wait_mode

	// Read is registered, so look one edge after it is taken
	task rd(input logic [15:0] a, input logic [23:0] e);
		@(posedge clk_sys);
		core_rd <= 1'b1;
		core_addr <= a;
		@(posedge clk_sys);
		core_rd <= 1'b0;
		@(posedge clk_sys);
		#1 chk("core rdata", e, core_rdata);
	endtask : rd

	task wr(input logic [15:0] a, input logic [23:0] d);
		@(posedge clk_sys);
		core_wr <= 1'b1;
		core_addr <= a;
		core_wdata <= d;
		@(posedge clk_sys);
		core_wr <= 1'b0;
	endtask : wr

	// host bytes high, mid, low back to back once host_ready is seen, no polling between them
	task host_word(input logic [23:0] w);
		for (int i = 0; i < 60 && host_ready !== 1'b1; i++)
			@(posedge clk_sys) #1;
		chk("host ready", 24'h1, host_ready);
		if (host_ready !== 1'b1)
			finish_test();
		@(posedge clk_sys);
		host_tx <= '{1'b1, BYTE_HIGH, w[23:16]};
		@(posedge clk_sys);
		host_tx <= '{1'b1, BYTE_MID, w[15:8]};
		@(posedge clk_sys);
		host_tx <= '{1'b1, BYTE_LOW, w[7:0]};
		@(posedge clk_sys);
		host_tx <= '0;
	endtask : host_word

	task test_host_boot;
		do_reset(MODE_NORMAL);
		repeat (6) @(posedge clk_sys);
		#1 chk("no load in mode 2", {2'h2, 1'b0}, {operating_mode, core_hold});
		do_reset(MODE_BOOT);
		wait_mode(MODE_BOOT, 8, 1'b0);
		host_word(24'h123456);
		host_word(24'hABCDEF);
		@(posedge clk_sys);
		host_flag_zero <= 1'b1;
		wait_mode(MODE_NORMAL, 12, 1'b1);
		@(posedge clk_sys);
		host_flag_zero <= 1'b0;
		rd(16'h0000, 24'h123456);
		rd(16'h0001, 24'hABCDEF);
		wr(16'h01FE, 24'h00C0DE);
		rd(16'h01FE, 24'h00C0DE);
		rd(16'h0200, 24'h000000);
		$display("test host boot done");
	endtask : test_host_boot

	task test_ext_boot;
		sel_ext <= 1'b1;
		operating_mode_register(MODE_BOOT, MODE_NORMAL);
		rd(16'h0000, 24'h000000);
		wait_mode(MODE_NORMAL, 20000, 1'b1);
		rd(16'h0000, ext_exp(0));
		rd(16'h0001, ext_exp(1));
		rd(16'h01FF, ext_exp(511));
		chk("hold after boot", 24'h0, core_hold);
		$display("test external boot done");
	endtask : test_ext_boot

	// Main sequence
	initial begin
		test_host_boot();
		test_ext_boot();
		finish_test();
	end
endmodule : tb_pbl_boot_ctrl
`default_nettype wire
